/* btf_trace_unit.v */
// Bus cycle trace capture with fault trigger and event interval timer.
//
// Overview of operation
// - A captured bus write into the top 16K address region is a fault.
// - An instruction start at an address outside the top 16K region is a fault.
// - With fault triggering armed, a fault raises the halt request that returns control.
// - After a fault the buffer keeps the preceding cycles and the offset points at the fault.
// - The fault kind output tells an illegal write from an out-of-range execution.
// - The six user probe inputs are stored in the auxiliary byte of every captured cycle.
// - The probe inputs are sampled on the same edge that latches the data bus.
// - The interval search reports the cycle count between two matched buffer events.
// - Both interval events are matched with the same pattern rules as one event search.
// - An instruction-start event matches only the cycle in which an instruction begins.
// - A finished interval reports its count and moves the offset to the second event.
// - Each event has its own direction and count, the second search starting next to the first hit.
// - Capture only observes the bus and never stalls the user program.
// - In fault mode up to 8191 cycles before the fault are retained, along with the fault cycle itself.
// - A search starts next to the current offset and runs forward unless backward is asked.
`timescale 1ns/100ps
`include "btf_map.vh"
module btf_trace_unit (
    input wire clk,
    input wire rst,
    input wire bus_strobe,
    input wire [15:0] bus_addr,
    input wire [7:0] bus_data,
    input wire bus_read,
    input wire bus_istart,
    input wire [5:0] user_probe_inputs,
    input wire trace_start,
    input wire fault_arm,
    input wire interval_start,
    input wire [`BTF_WORD_W-1:0] ev_a_value,
    input wire [`BTF_WORD_W-1:0] ev_a_mask,
    input wire ev_a_istart,
    input wire ev_a_back,
    input wire [13:0] ev_a_nth,
    input wire [`BTF_WORD_W-1:0] ev_b_value,
    input wire [`BTF_WORD_W-1:0] ev_b_mask,
    input wire ev_b_istart,
    input wire ev_b_back,
    input wire [13:0] ev_b_nth,
    output reg capture_active_r,
    output reg halt_request_r,
    output reg [1:0] fault_kind_r,
    output reg overflow_r,
    output reg [13:0] fill_r,
    output reg [13:0] trigger_offset_r,
    output reg [13:0] interval_cycles_r,
    output reg interval_done_r,
    output reg not_found_r,
    output wire search_busy
);
    localparam S_IDLE = 2'h0;
    localparam S_DRAIN = 2'h1;
    localparam S_READ = 2'h2;
    localparam S_CHECK = 2'h3;

    // Two-stage synchronisers for every pin coming from the processor bus.
    reg [32:0] pin_s1_r;
    reg [32:0] pin_s2_r;
    reg strobe_d_r;
    wire [32:0] pin_raw;
    wire strobe_s;
    wire strobe_rise;
    wire [`BTF_WORD_W-1:0] cycle_word;
    wire top_region;
    wire write_fault;
    wire exec_fault;
    wire fifo_in_ready;
    wire [33:0] fifo_out_data;
    wire fifo_out_valid;
    wire fifo_out_ready;
    wire fifo_push;

    // Buffer memory and search state.
    reg [`BTF_WORD_W-1:0] buf_mem [0:8191];
    reg [`BTF_WORD_W-1:0] rd_data_r;
    reg [`BTF_PTR_W-1:0] wr_ptr_r;
    reg [1:0] state_r;
    reg phase_r;
    reg [`BTF_POS_W-1:0] pos_r;
    reg [`BTF_POS_W-1:0] pos_a_r;
    reg [13:0] hits_r;
    reg [13:0] saved_trig_r;
    wire hit_a;
    wire hit_b;
    wire cur_hit;
    wire cur_back;
    wire [13:0] cur_nth;
    wire [13:0] need_hits;
    wire [`BTF_POS_W-1:0] step_a;
    wire [`BTF_POS_W-1:0] step_b;
    wire [`BTF_POS_W-1:0] step_cur;
    wire pos_out;
    wire [`BTF_PTR_W-1:0] oldest;
    wire [`BTF_POS_W-1:0] span;
    wire [13:0] fill_after;

    assign pin_raw = {bus_strobe, bus_addr, bus_data, user_probe_inputs, bus_istart, bus_read};
    assign strobe_s = pin_s2_r[32];

    // Pins pass two flops before any logic reads them.
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pin_s1_r <= {33{1'b0}};
            pin_s2_r <= {33{1'b0}};
            strobe_d_r <= 1'b0;
        end
        else
        begin
            pin_s1_r <= pin_raw;
            pin_s2_r <= pin_s1_r;
            strobe_d_r <= strobe_s;
        end
    end

    // Data, address and probes are latched together on the strobe edge.
    assign strobe_rise = strobe_s && !strobe_d_r;
    assign cycle_word = pin_s2_r[31:0];

    // Fault decode on the synchronised cycle.
    assign top_region = (cycle_word[`BTF_ADDR_MSB:`BTF_ADDR_MSB-1] == `BTF_TOP_REGION);
    assign write_fault = !cycle_word[`BTF_RW_BIT] && top_region;
    assign exec_fault = cycle_word[`BTF_ISTART_BIT] && !top_region;

    // Capture never waits on the bus; a full queue drops the cycle and flags it.
    assign fifo_push = capture_active_r && strobe_rise;

    btf_fifo #(
        .WIDTH(34),
        .DEPTH(`BTF_FIFO_DEPTH),
        .AW(`BTF_FIFO_AW)
    ) u_fifo (
        .clk(clk),
        .rst(rst),
        .clr(trace_start),
        .in_data({fault_arm && exec_fault, fault_arm && write_fault, cycle_word}),
        .in_valid(fifo_push),
        .in_ready(fifo_in_ready),
        .out_data(fifo_out_data),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready)
    );

    // The buffer drains the queue while idle and while a new search waits for it to empty.
    assign fifo_out_ready = (state_r == S_IDLE) || (state_r == S_DRAIN);

    // Capture session control, fault halt and overflow tracking.
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            capture_active_r <= 1'b0;
            halt_request_r <= 1'b0;
            fault_kind_r <= `BTF_FAULT_NONE;
            overflow_r <= 1'b0;
        end
        else if (trace_start)
        begin
            capture_active_r <= 1'b1;
            halt_request_r <= 1'b0;
            fault_kind_r <= `BTF_FAULT_NONE;
            overflow_r <= 1'b0;
        end
        else if (fifo_push)
        begin
            if (!fifo_in_ready)
            begin
                overflow_r <= 1'b1;
            end
            if (fault_arm && (write_fault || exec_fault))
            begin
                capture_active_r <= 1'b0;
                halt_request_r <= 1'b1;
                fault_kind_r <= write_fault ? `BTF_FAULT_WRITE : `BTF_FAULT_EXEC;
            end
        end
    end

    // Circular buffer write; it holds the newest 8192 cycles.
    assign fill_after = (fill_r == `BTF_BUF_DEPTH) ? fill_r : fill_r + 14'h0001;
    always @(posedge clk)
    begin
        if (fifo_out_valid && fifo_out_ready)
        begin
            buf_mem[wr_ptr_r] <= fifo_out_data[31:0];
        end
        rd_data_r <= buf_mem[oldest + pos_r[`BTF_PTR_W-1:0]];
    end

    // Event comparators for the two interval events.
    btf_event_match u_match_a (
        .word(rd_data_r),
        .value(ev_a_value),
        .mask(ev_a_mask),
        .istart_only(ev_a_istart),
        .hit(hit_a)
    );

    btf_event_match u_match_b (
        .word(rd_data_r),
        .value(ev_b_value),
        .mask(ev_b_mask),
        .istart_only(ev_b_istart),
        .hit(hit_b)
    );

    // Per-event direction and occurrence selection.
    assign step_a = ev_a_back ? 15'h7fff : 15'h0001;
    assign step_b = ev_b_back ? 15'h7fff : 15'h0001;
    assign cur_hit = phase_r ? hit_b : hit_a;
    assign cur_back = phase_r ? ev_b_back : ev_a_back;
    assign cur_nth = phase_r ? ev_b_nth : ev_a_nth;
    assign step_cur = cur_back ? 15'h7fff : 15'h0001;
    assign need_hits = (cur_nth == 14'h0000) ? 14'h0001 : cur_nth;
    assign oldest = wr_ptr_r - fill_r[`BTF_PTR_W-1:0];
    assign pos_out = pos_r[`BTF_POS_W-1] || (pos_r[13:0] >= fill_r);
    assign span = pos_r - pos_a_r;
    assign search_busy = (state_r != S_IDLE);

    // Buffer fill, trigger offset and the interval search machine.
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wr_ptr_r <= {`BTF_PTR_W{1'b0}};
            fill_r <= 14'h0000;
            trigger_offset_r <= 14'h0000;
            interval_cycles_r <= 14'h0000;
            interval_done_r <= 1'b0;
            not_found_r <= 1'b0;
            state_r <= S_IDLE;
            phase_r <= 1'b0;
            pos_r <= 15'h0000;
            pos_a_r <= 15'h0000;
            hits_r <= 14'h0000;
            saved_trig_r <= 14'h0000;
        end
        else
        begin
            interval_done_r <= 1'b0;
            if (trace_start)
            begin
                wr_ptr_r <= {`BTF_PTR_W{1'b0}};
                fill_r <= 14'h0000;
                trigger_offset_r <= 14'h0000;
            end
            else if (fifo_out_valid && fifo_out_ready)
            begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
                fill_r <= fill_after;
                if (fifo_out_data[33] || fifo_out_data[32])
                begin
                    trigger_offset_r <= fill_after - 14'h0001;
                end
            end
            case (state_r)
                S_IDLE:
                begin
                    if (interval_start && !trace_start)
                    begin
                        saved_trig_r <= trigger_offset_r;
                        phase_r <= 1'b0;
                        hits_r <= 14'h0000;
                        not_found_r <= 1'b0;
                        state_r <= S_DRAIN;
                    end
                end
                S_DRAIN:
                begin
                    // Wait for queued cycles so the search sees a settled buffer.
                    if (!fifo_out_valid)
                    begin
                        saved_trig_r <= trigger_offset_r;
                        pos_r <= {1'b0, trigger_offset_r} + step_a;
                        state_r <= S_READ;
                    end
                end
                S_READ:
                begin
                    if (pos_out)
                    begin
                        trigger_offset_r <= saved_trig_r;
                        not_found_r <= 1'b1;
                        interval_done_r <= 1'b1;
                        state_r <= S_IDLE;
                    end
                    else
                    begin
                        state_r <= S_CHECK;
                    end
                end
                S_CHECK:
                begin
                    if (cur_hit && (hits_r + 14'h0001 == need_hits))
                    begin
                        if (!phase_r)
                        begin
                            pos_a_r <= pos_r;
                            trigger_offset_r <= pos_r[13:0];
                            phase_r <= 1'b1;
                            hits_r <= 14'h0000;
                            pos_r <= pos_r + step_b;
                            state_r <= S_READ;
                        end
                        else
                        begin
                            // Each buffer entry is one processor cycle.
                            interval_cycles_r <= span[`BTF_POS_W-1] ?
                                (14'h0000 - span[13:0]) : span[13:0];
                            trigger_offset_r <= pos_r[13:0];
                            interval_done_r <= 1'b1;
                            state_r <= S_IDLE;
                        end
                    end
                    else
                    begin
                        hits_r <= hits_r + {13'h0000, cur_hit};
                        pos_r <= pos_r + step_cur;
                        state_r <= S_READ;
                    end
                end
                default:
                begin
                    state_r <= S_IDLE;
                end
            endcase
        end
    end
endmodule // btf_trace_unit

/* btf_map.vh */
// Constants for the bus trace fault timer: layouts, sizes and encodings.
`ifndef BTF_MAP_VH
`define BTF_MAP_VH

// Width and depth of the capture buffer and its index.
`define BTF_WORD_W 32
`define BTF_BUF_DEPTH 14'h2000
`define BTF_PTR_W 13
`define BTF_POS_W 15
`define BTF_FIFO_DEPTH 8
`define BTF_FIFO_AW 3

// Field positions inside one captured cycle word.
`define BTF_ADDR_MSB 31
`define BTF_ADDR_LSB 16
`define BTF_DATA_MSB 15
`define BTF_DATA_LSB 8
`define BTF_PROBE_MSB 7
`define BTF_PROBE_LSB 2
`define BTF_ISTART_BIT 1
`define BTF_RW_BIT 0

// Upper region decode: top two address bits both set.
`define BTF_TOP_REGION 2'h3

// Fault kind encodings.
`define BTF_FAULT_NONE 2'h0
`define BTF_FAULT_WRITE 2'h1
`define BTF_FAULT_EXEC 2'h2

`endif

/* btf_fifo.v */
// Small synchronous FIFO with valid and ready on both sides.
`timescale 1ns/100ps
module btf_fifo #(
    parameter WIDTH = 34,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    input wire clk,
    input wire rst,
    input wire clr,
    input wire [WIDTH-1:0] in_data,
    input wire in_valid,
    output wire in_ready,
    output wire [WIDTH-1:0] out_data,
    output wire out_valid,
    input wire out_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0] wr_ptr_r;
    reg [AW:0] rd_ptr_r;
    wire push;
    wire pop;

    // Full when the pointers differ only in the wrap bit.
    assign in_ready = (wr_ptr_r != {~rd_ptr_r[AW], rd_ptr_r[AW-1:0]});
    assign out_valid = (wr_ptr_r != rd_ptr_r);
    assign out_data = mem[rd_ptr_r[AW-1:0]];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Storage write.
    always @(posedge clk)
    begin
        if (push)
        begin
            mem[wr_ptr_r[AW-1:0]] <= in_data;
        end
    end

    // Pointer update; clear empties the queue.
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wr_ptr_r <= {(AW+1){1'b0}};
            rd_ptr_r <= {(AW+1){1'b0}};
        end
        else if (clr)
        begin
            wr_ptr_r <= {(AW+1){1'b0}};
            rd_ptr_r <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
            begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop)
            begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
        end
    end
endmodule // btf_fifo

/* btf_event_match.v */
// Pattern comparator for one event against one captured cycle word.
`timescale 1ns/100ps
`include "btf_map.vh"
module btf_event_match (
    input wire [`BTF_WORD_W-1:0] word,
    input wire [`BTF_WORD_W-1:0] value,
    input wire [`BTF_WORD_W-1:0] mask,
    input wire istart_only,
    output wire hit
);
    // Masked compare; an instruction-start event also needs the start flag.
    assign hit = (((word ^ value) & mask) == {`BTF_WORD_W{1'b0}}) &&
                 (!istart_only || word[`BTF_ISTART_BIT]);
endmodule // btf_event_match

/* btf_trace_unit_assertions.sv */
// Port-level assertions for the bus trace fault timer.
`timescale 1ns/100ps
`include "btf_map.vh"
module btf_chk (
    input wire clk,
    input wire rst,
    input wire trace_start,
    input wire fault_arm,
    input wire interval_start,
    input wire capture_active_r,
    input wire halt_request_r,
    input wire [1:0] fault_kind_r,
    input wire [13:0] fill_r,
    input wire [13:0] trigger_offset_r,
    input wire interval_done_r,
    input wire not_found_r,
    input wire search_busy
);
    // All checks run on the one clock and rest while reset is high.
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // A halt always names the kind of fault behind it.
    AST_HALT_KIND: assert property ($rose(halt_request_r) |-> fault_kind_r != 2'h0)
        else $error("halt raised with no fault kind");
    AST_HALT_ARM: assert property ($rose(halt_request_r) |-> $past(fault_arm))
        else $error("halt raised while fault detection was off");
    AST_HALT_HOLD: assert property (halt_request_r && !trace_start |=> halt_request_r)
        else $error("halt request dropped on its own");
    AST_CLEAR: assert property (trace_start |=> !halt_request_r && fault_kind_r == 2'h0)
        else $error("trace start left a fault standing");
    AST_STOP: assert property ($rose(halt_request_r) |-> ##[0:4] !capture_active_r)
        else $error("capture kept running after a fault");
    AST_FILL_MAX: assert property (fill_r <= 14'h2000)
        else $error("fill count above buffer depth");
    AST_FILL_STEP: assert property (fill_r != $past(fill_r) |-> fill_r == 14'h0
        || fill_r == $past(fill_r) + 14'h1)
        else $error("fill count jumped");
    AST_BUSY: assert property (interval_start && !search_busy |=> search_busy)
        else $error("interval start not taken");
    AST_DONE_PULSE: assert property (interval_done_r |=> !interval_done_r)
        else $error("done longer than one cycle");
    AST_MISS: assert property ($rose(not_found_r) |-> interval_done_r)
        else $error("not found raised outside done");
    AST_OFFSET: assert property (interval_done_r && !not_found_r |-> trigger_offset_r < fill_r)
        else $error("offset left the filled buffer");

    // Main scenarios reached by the bench.
    COV_WRITE: cover property ($rose(halt_request_r) && fault_kind_r == 2'h1);
    COV_EXEC: cover property ($rose(halt_request_r) && fault_kind_r == 2'h2);
    COV_HIT: cover property (interval_done_r && !not_found_r);
    COV_MISS: cover property (interval_done_r && not_found_r);
endmodule // btf_chk

/* btf_mcu_model.sv */
// Behavioural processor bus model driving the trace unit pins.
`timescale 1ns/100ps
module btf_mcu_model (
    input wire clk,
    output reg bus_strobe,
    output reg [15:0] bus_addr,
    output reg [7:0] bus_data,
    output reg bus_read,
    output reg bus_istart,
    output reg [5:0] user_probe_inputs
);
    // Idle pin levels; the probe pins sit at their pull-up level.
    initial
    begin
        bus_strobe = 1'b0;
        bus_addr = 16'h0000;
        bus_data = 8'h00;
        bus_read = 1'b1;
        bus_istart = 1'b0;
        user_probe_inputs = 6'h3f;
    end

    // One cycle: pins settle, the strobe pulses, then data and probes are let go.
    task cyc(input [15:0] a, input [7:0] d, input rd, input ist, input [5:0] p);
    begin
        @(posedge clk);
        bus_addr <= a;
        bus_data <= d;
        bus_read <= rd;
        bus_istart <= ist;
        user_probe_inputs <= p;
        repeat (3) @(posedge clk);
        bus_strobe <= 1'b1;
        repeat (3) @(posedge clk);
        bus_strobe <= 1'b0;
        repeat (2) @(posedge clk);
        bus_data <= ~d;
        user_probe_inputs <= 6'h3f;
    end
    endtask
endmodule // btf_mcu_model

/* testbench.sv */
// Self-checking bench for the bus trace fault timer.
`timescale 1ns/100ps
`include "btf_map.vh"
module testbench;
    reg clk, rst, trace_start, fault_arm, interval_start;
    reg [31:0] ev_a_value, ev_a_mask, ev_b_value, ev_b_mask;
    reg ev_a_istart, ev_a_back, ev_b_istart, ev_b_back;
    reg [13:0] ev_a_nth, ev_b_nth;
    wire bus_strobe, bus_read, bus_istart, search_busy;
    wire [15:0] bus_addr;
    wire [7:0] bus_data;
    wire [5:0] user_probe_inputs;
    wire capture_active_r, halt_request_r, overflow_r, interval_done_r, not_found_r;
    wire [1:0] fault_kind_r;
    wire [13:0] fill_r, trigger_offset_r, interval_cycles_r;
    integer fail_count, total_checks, i;

    btf_mcu_model btf_mcu_model_inst (.clk(clk), .bus_strobe(bus_strobe),
        .bus_addr(bus_addr), .bus_data(bus_data), .bus_read(bus_read),
        .bus_istart(bus_istart), .user_probe_inputs(user_probe_inputs));
    btf_trace_unit btf_trace_unit_inst (.clk(clk), .rst(rst), .bus_strobe(bus_strobe),
        .bus_addr(bus_addr), .bus_data(bus_data), .bus_read(bus_read),
        .bus_istart(bus_istart), .user_probe_inputs(user_probe_inputs),
        .trace_start(trace_start), .fault_arm(fault_arm), .interval_start(interval_start),
        .ev_a_value(ev_a_value), .ev_a_mask(ev_a_mask), .ev_a_istart(ev_a_istart),
        .ev_a_back(ev_a_back), .ev_a_nth(ev_a_nth), .ev_b_value(ev_b_value),
        .ev_b_mask(ev_b_mask), .ev_b_istart(ev_b_istart), .ev_b_back(ev_b_back),
        .ev_b_nth(ev_b_nth), .capture_active_r(capture_active_r),
        .halt_request_r(halt_request_r), .fault_kind_r(fault_kind_r),
        .overflow_r(overflow_r), .fill_r(fill_r), .trigger_offset_r(trigger_offset_r),
        .interval_cycles_r(interval_cycles_r), .interval_done_r(interval_done_r),
        .not_found_r(not_found_r), .search_busy(search_busy));

    // Clock at 5 ns period.
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Compares one value and counts the result.
    task check(input [31:0] seen, input [31:0] exp);
    begin
        total_checks = total_checks + 1;
        if (seen !== exp)
        begin
            fail_count = fail_count + 1;
            $display("MISMATCH at %0t: got %h expected %h", $time, seen, exp);
        end
    end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task wrap_up;
    begin
        $display("Checks %0d, mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    end
    endtask

    // Pulses trace start with the given fault mode.
    task start_trace(input arm);
    begin
        @(posedge clk);
        fault_arm <= arm;
        trace_start <= 1'b1;
        @(posedge clk);
        trace_start <= 1'b0;
    end
    endtask

    // Runs one interval search; flags are istart then backward.
    task ivl(input [31:0] av, am, input [1:0] af, input [13:0] an, input [31:0] bv, bm,
        input [1:0] bf, input [13:0] bn, input [13:0] ec, eo, input enf);
        integer n;
    begin
        @(posedge clk);
        {ev_a_value, ev_a_mask, ev_a_istart, ev_a_back, ev_a_nth} <= {av, am, af, an};
        {ev_b_value, ev_b_mask, ev_b_istart, ev_b_back, ev_b_nth} <= {bv, bm, bf, bn};
        interval_start <= 1'b1;
        @(posedge clk);
        interval_start <= 1'b0;
        #1;
        n = 0;
        while (interval_done_r !== 1'b1 && n < 3000)
        begin
            @(posedge clk);
            #1;
            n = n + 1;
        end
        if (n == 3000)
        begin
            fail_count = fail_count + 1;
            $display("MISMATCH at %0t: search never finished", $time);
            wrap_up;
        end
        check(not_found_r, enf);
        check(trigger_offset_r, eo);
        if (!enf)
            check(interval_cycles_r, ec);
        @(posedge clk);
        #1;
        check(search_busy, 1'b0);
    end
    endtask

    // Illegal write into the top region, after near-boundary legal cycles.
    task test_write_fault;
    begin
        start_trace(1'b1);
        btf_mcu_model_inst.cyc(16'hc000, 8'h86, 1'b1, 1'b1, 6'h01);
        btf_mcu_model_inst.cyc(16'hbfff, 8'h11, 1'b0, 1'b0, 6'h02);
        btf_mcu_model_inst.cyc(16'hc002, 8'h7a, 1'b1, 1'b1, 6'h03);
        check(halt_request_r, 1'b0);
        btf_mcu_model_inst.cyc(16'hc010, 8'h22, 1'b0, 1'b0, 6'h04);
        check(halt_request_r, 1'b1);
        check(fault_kind_r, `BTF_FAULT_WRITE);
        check(fill_r, 14'h4);
        check(trigger_offset_r, 14'h3);
        check(capture_active_r, 1'b0);
        check(overflow_r, 1'b0);
        $display("Test write fault done");
    end
    endtask

    // Instruction start below the top region.
    task test_exec_fault;
    begin
        start_trace(1'b1);
        #1;
        check(halt_request_r, 1'b0);
        check(capture_active_r, 1'b1);
        btf_mcu_model_inst.cyc(16'hc000, 8'h86, 1'b1, 1'b1, 6'h01);
        btf_mcu_model_inst.cyc(16'h8000, 8'h01, 1'b1, 1'b1, 6'h02);
        check(halt_request_r, 1'b1);
        check(fault_kind_r, `BTF_FAULT_EXEC);
        check(fill_r, 14'h2);
        check(trigger_offset_r, 14'h1);
        $display("Test exec fault done");
    end
    endtask

    // Eight cycles without fault mode, then four interval searches.
    task test_interval;
    begin
        start_trace(1'b0);
        for (i = 0; i < 8; i = i + 1)
            btf_mcu_model_inst.cyc((i == 2 || i == 3 || i == 6) ? 16'hf700 : 16'hf000 + i[15:0],
                i[7:0], i != 7, i != 3, i[5:0]);
        check(halt_request_r, 1'b0);
        check(fill_r, 14'h8);
        check(capture_active_r, 1'b1);
        check(overflow_r, 1'b0);
        ivl(32'hf7000000, 32'hffff0000, 2'h2, 14'h1, 32'hf7000000, 32'hffff0000, 2'h0,
            14'h1, 14'h1, 14'h3, 1'b0);
        ivl(32'hf7000000, 32'hffff0000, 2'h3, 14'h1, 32'hf7000000, 32'hffff0000, 2'h2,
            14'h1, 14'h4, 14'h6, 1'b0);
        ivl(32'h00000514, 32'h0000fffc, 2'h1, 14'h1, 32'hf0010000, 32'hffff0000, 2'h3,
            14'h1, 14'h4, 14'h1, 1'b0);
        ivl(32'hf7000000, 32'hffff0000, 2'h2, 14'h3, 32'hf7000000, 32'hffff0000, 2'h2,
            14'h1, 14'h0, 14'h1, 1'b1);
        $display("Test interval done");
    end
    endtask

    // Main sequence: reset, then every scenario.
    initial
    begin
        {rst, trace_start, fault_arm, interval_start} = 4'h8;
        {ev_a_value, ev_a_mask, ev_b_value, ev_b_mask} = 128'h0;
        {ev_a_istart, ev_a_back, ev_b_istart, ev_b_back} = 4'h0;
        ev_a_nth = 14'h1;
        ev_b_nth = 14'h1;
        fail_count = 0;
        total_checks = 0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        #1;
        check(halt_request_r, 1'b0);
        check(fill_r, 14'h0);
        test_write_fault;
        test_exec_fault;
        test_interval;
        wrap_up;
    end
endmodule // testbench

bind btf_trace_unit btf_chk btf_chk_inst (.clk(clk), .rst(rst), .trace_start(trace_start),
    .fault_arm(fault_arm), .interval_start(interval_start),
    .capture_active_r(capture_active_r), .halt_request_r(halt_request_r),
    .fault_kind_r(fault_kind_r), .fill_r(fill_r), .trigger_offset_r(trigger_offset_r),
    .interval_done_r(interval_done_r), .not_found_r(not_found_r),
    .search_busy(search_busy));
